// *** rtl/ir_capture_pkg.sv ***
// Constants and types shared by the infrared receive-capture and envelope logic
package ir_capture_pkg;
   localparam int          TIMER_W         = 16;
   localparam int          CLK_PERIOD_NS   = 10;
   localparam logic [15:0] TIMER_ZERO      = 16'h0000;
   localparam logic [15:0] TIMER_ONE       = 16'h0001;
   localparam logic [15:0] TIMER_MAX       = 16'hffff;
   localparam logic [1:0]  ENV_OFF         = 2'h0;
   localparam logic [1:0]  ENV_MODULATED   = 2'h1;
   localparam logic [1:0]  ENV_UNMODULATED = 2'h2;
   localparam logic [1:0]  EDGE_FALL       = 2'h0;
   localparam logic [1:0]  EDGE_RISE       = 2'h1;
   localparam logic [1:0]  EDGE_BOTH       = 2'h2;
   localparam logic [1:0]  EDGE_BOTH_ALT   = 2'h3;
   localparam logic [1:0]  ABSENCE_PERIODS = 2'h2;
   localparam logic [1:0]  ABSENCE_ZERO    = 2'h0;
   localparam logic [1:0]  ABSENCE_STEP    = 2'h1;

   typedef enum logic [0:0] {
      RX_WAIT_FIRST = 1'b0,
      RX_COUNTING   = 1'b1
   } rx_state_t;
endpackage : ir_capture_pkg

// *** rtl/rx_edge_if.sv ***
// Edge information passed from the receive pin qualifier to the capture logic
`timescale 1ns/1ns
`default_nettype none
interface rx_edge_if;
   logic [1:0] edge_select;
   logic       qualified;
   logic       rising;
   logic       level;

   modport qualifier (input edge_select, output qualified, output rising, output level);
   modport consumer  (output edge_select, input qualified, input rising, input level);
endinterface : rx_edge_if
`default_nettype wire

// *** rtl/rx_edge_qualifier.sv ***
// Synchroniser and edge qualifier for the infrared receive pin
`timescale 1ns/1ns
`default_nettype none
module rx_edge_qualifier (
   input  wire logic  i_clk,
   input  wire logic  i_rst_n,
   input  wire logic  i_receive_in_pin,
   rx_edge_if.qualifier edges
);
   logic pin_meta;
   logic pin_sync;
   logic pin_prev;
   wire  rise_seen;
   wire  fall_seen;

   // Two stages before any logic looks at the pin
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      // Reset to the pin's idle high level so release shows no false edge
      if (!i_rst_n) begin
         pin_meta <= 1'b1;
         pin_sync <= 1'b1;
         pin_prev <= 1'b1;
      end else begin
         pin_meta <= i_receive_in_pin;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   assign rise_seen = pin_sync & ~pin_prev;
   assign fall_seen = ~pin_sync & pin_prev;

   // One pulse per transition, filtered by the selected edge kind
   assign edges.qualified =
      (edges.edge_select == ir_capture_pkg::EDGE_FALL) ? fall_seen :
      (edges.edge_select == ir_capture_pkg::EDGE_RISE) ? rise_seen :
      (rise_seen | fall_seen);
   assign edges.rising = rise_seen;
   assign edges.level  = pin_sync;
endmodule : rx_edge_qualifier
`default_nettype wire

// *** rtl/ir_receive_capture_envelope.sv ***
// Infrared timer receive capture, burst count and external envelope output
//
// Contract
// - Envelope select 01b or 10b drives envelope pin
// - Polarity 0: envelope pin follows modulation bit
// - Polarity 1: envelope pin carries inverted modulation bit
// - Carrier pin modulated for 01b, unmodulated for 10b
// - Receive mode when direction 0 and enabled
// - Edge select picks qualifying receive transitions
// - First qualified event starts timer from zero
// - Timer ticks per carrier cycle or per clock
// - Later event loads data bit with pin level
// - Later event copies timer into modulator time
// - Reload bit clears timer on event, counting continues
// - Timer wrap before event sets overflow flag
// - Receive runs until transmit or disable
// - Standard receive sets interrupt flag per capture
// - Burst mode stops capture into modulator time
// - Burst mode counts qualified edges in modulator time
// - Two carrier periods without edge set flag
// - Entering burst mode loads modulator time 0001h
// - Burst mode keeps frequency measure and reload
// - Interrupt request only while interrupt enable set
`timescale 1ns/1ns
`default_nettype none
module ir_receive_capture_envelope (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_timer_enable,
   input  wire logic        i_direction_bit,
   input  wire logic [1:0]  i_edge_select,
   input  wire logic        i_frequency_measure,
   input  wire logic        i_capture_reload,
   input  wire logic        i_burst_count_mode,
   input  wire logic        i_timer_interrupt_enable,
   input  wire logic [1:0]  i_envelope_select,
   input  wire logic        i_output_polarity,
   input  wire logic        i_modulation_bit,
   input  wire logic [15:0] i_carrier_period,
   input  wire logic        i_carrier_wave,
   input  wire logic        i_tx_interval_boundary,
   input  wire logic        i_receive_in_pin,
   input  wire logic        i_clear_overflow,
   input  wire logic        i_clear_interrupt,
   output logic             o_envelope_out_pin,
   output logic             o_carrier_out_pin,
   output logic [15:0]      o_timer_value,
   output logic [15:0]      o_modulator_time,
   output logic             o_captured_bit,
   output logic             o_overflow_flag,
   output logic             o_timer_interrupt_flag,
   output logic             o_irq,
   output logic             o_receive_active
);
   // Reset release synchroniser
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // Receive pin edges
   rx_edge_if edges ();

   assign edges.edge_select = i_edge_select;

   rx_edge_qualifier u_edge (
      .i_clk            (i_clk),
      .i_rst_n          (rst_n),
      .i_receive_in_pin (i_receive_in_pin),
      .edges            (edges)
   );

   // State
   ir_capture_pkg::rx_state_t rx_state;
   ir_capture_pkg::rx_state_t next_rx_state;
   logic [15:0]               carrier_cnt;
   logic [15:0]               next_carrier_cnt;
   logic [15:0]               timer_value;
   logic [15:0]               next_timer_value;
   logic [15:0]               modulator_time;
   logic [15:0]               next_modulator_time;
   logic [1:0]                absence_cnt;
   logic [1:0]                next_absence_cnt;
   logic                      absence_armed;
   logic                      next_absence_armed;
   logic                      burst_prev;
   logic                      captured_bit;
   logic                      overflow_flag;
   logic                      interrupt_flag;
   logic                      tx_prev;
   logic                      envelope;
   logic                      next_envelope;
   logic                      mod_hold;
   logic                      carrier_out;

   // Decode
   wire rx_active;
   wire tx_active;
   wire tx_start;
   wire tx_sample;
   wire carrier_tick;
   wire timer_inc;
   wire first_event;
   wire later_event;
   wire burst_enter;
   wire burst_edge;
   wire absence_last;
   wire absence_hit;
   wire timer_at_max;
   wire std_capture;
   wire reload_hit;
   wire overflow_set;
   wire interrupt_set;
   wire envelope_en;
   wire carrier_mod;
   wire next_carrier_out;

   assign rx_active    = i_timer_enable & ~i_direction_bit;
   assign tx_active    = i_timer_enable & i_direction_bit;
   assign tx_start     = tx_active & ~tx_prev;
   assign tx_sample    = tx_start | (tx_active & i_tx_interval_boundary);
   assign carrier_tick = rx_active & (carrier_cnt == i_carrier_period);
   // Carrier ticks or raw clocks, in both receive variants
   assign timer_inc    = (rx_state == ir_capture_pkg::RX_COUNTING) &
                         (i_frequency_measure | carrier_tick);
   assign first_event  = rx_active & (rx_state == ir_capture_pkg::RX_WAIT_FIRST) & edges.qualified;
   assign later_event  = rx_active & (rx_state == ir_capture_pkg::RX_COUNTING) & edges.qualified;
   assign burst_enter  = i_burst_count_mode & ~burst_prev;
   assign burst_edge   = rx_active & i_burst_count_mode & edges.qualified;
   assign absence_last = absence_cnt == (ir_capture_pkg::ABSENCE_PERIODS - ir_capture_pkg::ABSENCE_STEP);
   // An edge in the tick that ends the second period still counts as carrier
   assign absence_hit  = rx_active & i_burst_count_mode & absence_armed & carrier_tick &
                         absence_last & ~edges.qualified;
   assign timer_at_max = timer_value == ir_capture_pkg::TIMER_MAX;
   assign std_capture  = later_event & ~i_burst_count_mode;
   assign reload_hit   = later_event & i_capture_reload;
   // A wrap in the same cycle as an event is not an overflow
   assign overflow_set  = rx_active & timer_inc & ~later_event & timer_at_max;
   assign interrupt_set = std_capture | absence_hit;

   assign envelope_en = (i_envelope_select == ir_capture_pkg::ENV_MODULATED) |
                        (i_envelope_select == ir_capture_pkg::ENV_UNMODULATED);
   assign carrier_mod = (i_envelope_select == ir_capture_pkg::ENV_UNMODULATED) ?
                        i_carrier_wave : (i_carrier_wave & mod_hold);
   assign next_carrier_out = tx_active ? (carrier_mod ^ i_output_polarity) : i_output_polarity;

   // Receive sequencing
   always_comb begin
      next_rx_state = rx_state;
      case (rx_state)
         ir_capture_pkg::RX_WAIT_FIRST: begin
            if (first_event) begin
               next_rx_state = ir_capture_pkg::RX_COUNTING;
            end
         end
         ir_capture_pkg::RX_COUNTING: begin
            if (!rx_active) begin
               next_rx_state = ir_capture_pkg::RX_WAIT_FIRST;
            end
         end
         default: begin
            next_rx_state = ir_capture_pkg::RX_WAIT_FIRST;
         end
      endcase
   end

   // Carrier period divider, runs only in receive
   // Cleared outside receive so each start begins a full carrier cycle
   always_comb begin
      if (!rx_active || carrier_tick) begin
         next_carrier_cnt = ir_capture_pkg::TIMER_ZERO;
      end else begin
         next_carrier_cnt = carrier_cnt + ir_capture_pkg::TIMER_ONE;
      end
   end

   // Timer value
   always_comb begin
      next_timer_value = timer_value;
      if (first_event) begin
         next_timer_value = ir_capture_pkg::TIMER_ZERO;
      end else if (reload_hit) begin
         next_timer_value = ir_capture_pkg::TIMER_ZERO;
      end else if (rx_active && timer_inc) begin
         next_timer_value = timer_value + ir_capture_pkg::TIMER_ONE;
      end
   end

   // Modulator time: capture, or edge count in burst mode
   always_comb begin
      next_modulator_time = modulator_time;
      if (burst_enter) begin
         next_modulator_time = ir_capture_pkg::TIMER_ONE;
      end else if (burst_edge) begin
         next_modulator_time = modulator_time + ir_capture_pkg::TIMER_ONE;
      end else if (std_capture) begin
         next_modulator_time = timer_value;
      end
   end

   // Carrier absence watch, re-armed by every qualified edge
   always_comb begin
      next_absence_cnt   = absence_cnt;
      next_absence_armed = absence_armed;
      if (!rx_active || !i_burst_count_mode) begin
         next_absence_cnt   = ir_capture_pkg::ABSENCE_ZERO;
         next_absence_armed = 1'b0;
      end else if (edges.qualified) begin
         next_absence_cnt   = ir_capture_pkg::ABSENCE_ZERO;
         next_absence_armed = 1'b1;
      end else if (absence_hit) begin
         next_absence_cnt   = ir_capture_pkg::ABSENCE_ZERO;
         next_absence_armed = 1'b0; // One flag per space
      end else if (carrier_tick) begin
         next_absence_cnt   = absence_cnt + ir_capture_pkg::ABSENCE_STEP;
      end
   end

   // Envelope pin, sampled at transmit start and interval boundaries
   always_comb begin
      next_envelope = envelope;
      if (!tx_active || !envelope_en) begin
         next_envelope = i_output_polarity;
      end else if (tx_sample) begin
         next_envelope = i_modulation_bit ^ i_output_polarity;
      end
   end

   // Timer holds while receive is off; a restart waits for a new first edge
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_state    <= ir_capture_pkg::RX_WAIT_FIRST;
         timer_value <= ir_capture_pkg::TIMER_ZERO;
      end else begin
         rx_state    <= next_rx_state;
         timer_value <= next_timer_value;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         carrier_cnt <= ir_capture_pkg::TIMER_ZERO;
      end else begin
         carrier_cnt <= next_carrier_cnt;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         absence_cnt   <= ir_capture_pkg::ABSENCE_ZERO;
         absence_armed <= 1'b0;
      end else begin
         absence_cnt   <= next_absence_cnt;
         absence_armed <= next_absence_armed;
      end
   end

   // Previous-cycle copies for the burst entry and transmit start detectors
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         burst_prev <= 1'b0;
         tx_prev    <= 1'b0;
      end else begin
         burst_prev <= i_burst_count_mode;
         tx_prev    <= tx_active;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         modulator_time <= ir_capture_pkg::TIMER_ZERO;
      end else begin
         modulator_time <= next_modulator_time;
      end
   end

   // Captured level also follows edges in burst mode
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         captured_bit <= 1'b0;
      end else if (later_event) begin
         captured_bit <= edges.rising;
      end
   end

   // Set wins over a clear in the same cycle; no later event drops a flag
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         overflow_flag <= 1'b0;
      end else begin
         overflow_flag <= overflow_set | (overflow_flag & ~i_clear_overflow);
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         interrupt_flag <= 1'b0;
      end else begin
         interrupt_flag <= interrupt_set | (interrupt_flag & ~i_clear_interrupt);
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         envelope    <= 1'b0;
         carrier_out <= 1'b0;
      end else begin
         envelope    <= next_envelope;
         carrier_out <= next_carrier_out;
      end
   end

   // Modulation bit held between boundaries to gate the carrier
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         mod_hold <= 1'b0;
      end else if (tx_sample) begin
         mod_hold <= i_modulation_bit;
      end
   end

   assign o_envelope_out_pin     = envelope;
   assign o_carrier_out_pin      = carrier_out;
   assign o_timer_value          = timer_value;
   assign o_modulator_time       = modulator_time;
   assign o_captured_bit         = captured_bit;
   assign o_overflow_flag        = overflow_flag;
   assign o_timer_interrupt_flag = interrupt_flag;
   assign o_irq                  = i_timer_interrupt_enable & (overflow_flag | interrupt_flag);
   assign o_receive_active       = rx_active;
endmodule : ir_receive_capture_envelope
`default_nettype wire

// *** verif/ir_capture_asserts.sv ***
// Port-level checks for the infrared capture and envelope block
`timescale 1ns/1ns
`default_nettype none
module ir_capture_asserts (
   input wire logic        i_clk,
   input wire logic        i_rst_n,
   input wire logic        i_timer_enable,
   input wire logic        i_direction_bit,
   input wire logic        i_capture_reload,
   input wire logic        i_burst_count_mode,
   input wire logic        i_timer_interrupt_enable,
   input wire logic [1:0]  i_envelope_select,
   input wire logic        i_output_polarity,
   input wire logic        i_modulation_bit,
   input wire logic        i_tx_interval_boundary,
   input wire logic        i_clear_overflow,
   input wire logic        o_envelope_out_pin,
   input wire logic [15:0] o_timer_value,
   input wire logic [15:0] o_modulator_time,
   input wire logic        o_overflow_flag,
   input wire logic        o_timer_interrupt_flag,
   input wire logic        o_irq,
   input wire logic        o_receive_active
);
   logic [2:0] up;
   // Design holds state two edges past reset; wait until it can move
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) up <= 3'h0;
      else up <= {up[1:0], 1'b1};
   end
   wire logic live = up[2];
   wire logic tx = i_timer_enable & i_direction_bit;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!live);

   property p_irq_gate;
      o_irq == (i_timer_interrupt_enable & (o_overflow_flag | o_timer_interrupt_flag));
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq gating wrong");
   property p_rx_active;
      o_receive_active == (i_timer_enable & ~i_direction_bit);
   endproperty
   a_rx_active: assert property (p_rx_active) else $error("receive active wrong");
   property p_env_idle;
      !tx |=> o_envelope_out_pin == $past(i_output_polarity);
   endproperty
   a_env_idle: assert property (p_env_idle) else $error("envelope idle level wrong");
   property p_env_follow;
      tx && $past(tx) && i_tx_interval_boundary && (i_envelope_select == 2'h1 || i_envelope_select == 2'h2)
         |=> o_envelope_out_pin == $past(i_modulation_bit ^ i_output_polarity);
   endproperty
   a_env_follow: assert property (p_env_follow) else $error("envelope level wrong");
   property p_capture;
      $rose(o_timer_interrupt_flag) && !$past(i_burst_count_mode) |-> o_modulator_time == $past(o_timer_value);
   endproperty
   a_capture: assert property (p_capture) else $error("capture value wrong");
   property p_reload;
      $rose(o_timer_interrupt_flag) && !$past(i_burst_count_mode) && $past(i_capture_reload)
         |-> o_timer_value == 16'h0000;
   endproperty
   a_reload: assert property (p_reload) else $error("timer not cleared");
   property p_ovf;
      $rose(o_overflow_flag) |-> $past(o_timer_value) == 16'hffff;
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow without wrap");
   property p_burst_entry;
      $rose(i_burst_count_mode) |=> o_modulator_time == 16'h0001;
   endproperty
   a_burst_entry: assert property (p_burst_entry) else $error("burst entry count wrong");
   property p_hold;
      !o_receive_active |=> $stable(o_timer_value);
   endproperty
   a_hold: assert property (p_hold) else $error("timer moved while stopped");
   property p_sticky;
      o_overflow_flag && !i_clear_overflow && !$past(i_clear_overflow) |=> o_overflow_flag;
   endproperty
   a_sticky: assert property (p_sticky) else $error("overflow flag dropped");
endmodule : ir_capture_asserts
bind ir_receive_capture_envelope ir_capture_asserts u_asserts (
   .i_clk, .i_rst_n, .i_timer_enable, .i_direction_bit, .i_capture_reload, .i_burst_count_mode,
   .i_timer_interrupt_enable, .i_envelope_select, .i_output_polarity, .i_modulation_bit,
   .i_tx_interval_boundary, .i_clear_overflow, .o_envelope_out_pin, .o_timer_value,
   .o_modulator_time, .o_overflow_flag, .o_timer_interrupt_flag, .o_irq, .o_receive_active);
`default_nettype wire

// *** verif/ir_front_end_model.sv ***
// Optical receiver front end driving the receive pin
`timescale 1ns/1ns
`default_nettype none
module ir_front_end_model (
   input  wire logic i_clk,
   output logic      o_pin
);
   // Receiver output idles high through its pull-up
   initial o_pin = 1'b1;
   task automatic set_level(input logic lvl);
      o_pin = lvl;
   endtask : set_level
   task automatic burst(input int n, input int half);
      repeat (n) begin
         o_pin = ~o_pin;
         repeat (half) @(negedge i_clk);
      end
   endtask : burst
endmodule : ir_front_end_model
`default_nettype wire

// *** verif/testbench.sv ***
// Directed bench for the infrared capture and envelope block
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic        i_clk = 1'b0;
   logic        i_rst_n, i_timer_enable, i_direction_bit, i_frequency_measure, i_capture_reload;
   logic        i_burst_count_mode, i_timer_interrupt_enable, i_output_polarity, i_modulation_bit;
   logic        i_carrier_wave, i_tx_interval_boundary, i_clear_overflow, i_clear_interrupt;
   logic [1:0]  i_edge_select, i_envelope_select;
   logic [15:0] i_carrier_period, o_timer_value, o_modulator_time, timer_before;
   wire logic   i_receive_in_pin;
   logic        o_envelope_out_pin, o_carrier_out_pin, o_captured_bit, o_overflow_flag;
   logic        o_timer_interrupt_flag, o_irq, o_receive_active;
   int          miscompares = 0;
   int          checks = 0;

   initial forever #5 i_clk = ~i_clk;
   ir_front_end_model fe (.i_clk(i_clk), .o_pin(i_receive_in_pin));
   ir_receive_capture_envelope u_dut (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_timer_enable(i_timer_enable),
      .i_direction_bit(i_direction_bit), .i_edge_select(i_edge_select),
      .i_frequency_measure(i_frequency_measure), .i_capture_reload(i_capture_reload),
      .i_burst_count_mode(i_burst_count_mode), .i_timer_interrupt_enable(i_timer_interrupt_enable),
      .i_envelope_select(i_envelope_select), .i_output_polarity(i_output_polarity),
      .i_modulation_bit(i_modulation_bit), .i_carrier_period(i_carrier_period),
      .i_carrier_wave(i_carrier_wave), .i_tx_interval_boundary(i_tx_interval_boundary),
      .i_receive_in_pin(i_receive_in_pin), .i_clear_overflow(i_clear_overflow),
      .i_clear_interrupt(i_clear_interrupt), .o_envelope_out_pin(o_envelope_out_pin),
      .o_carrier_out_pin(o_carrier_out_pin), .o_timer_value(o_timer_value),
      .o_modulator_time(o_modulator_time), .o_captured_bit(o_captured_bit),
      .o_overflow_flag(o_overflow_flag), .o_timer_interrupt_flag(o_timer_interrupt_flag),
      .o_irq(o_irq), .o_receive_active(o_receive_active));

   task automatic chk1(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk1
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk16
   task automatic tick(input int n);
      repeat (n) @(negedge i_clk);
   endtask : tick
   task automatic tally_and_finish;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish
   task automatic env_step(input logic m);
      i_modulation_bit = m;
      i_tx_interval_boundary = 1'b1;
      tick(1);
      i_tx_interval_boundary = 1'b0;
      tick(1);
   endtask : env_step
   // Pin change, results checked, flag cleared; gap counts to the next change
   task automatic rx_edge(input logic lvl, input int gap, input logic [15:0] mt, input logic b, input logic f);
      fe.set_level(lvl);
      tick(6);
      chk16(o_modulator_time, mt);
      chk1(o_captured_bit, b);
      chk1(o_timer_interrupt_flag, f);
      chk1(o_irq, f & i_timer_interrupt_enable);
      i_clear_interrupt = 1'b1;
      tick(1);
      i_clear_interrupt = 1'b0;
      tick(gap - 7);
   endtask : rx_edge

   initial begin
      {i_rst_n, i_timer_enable, i_direction_bit, i_frequency_measure, i_capture_reload} = 5'h00;
      {i_burst_count_mode, i_timer_interrupt_enable, i_output_polarity, i_modulation_bit} = 4'h0;
      {i_tx_interval_boundary, i_clear_overflow, i_clear_interrupt} = 3'h0;
      {i_edge_select, i_envelope_select} = 4'h0;
      i_carrier_wave = 1'b1;
      i_carrier_period = 16'h0003;
      tick(6);
      i_rst_n = 1'b1;
      tick(3);
      i_timer_enable = 1'b1;
      i_direction_bit = 1'b1;
      tick(2);
      chk1(o_receive_active, 1'b0);
      for (int k = 0; k < 4; k++) begin
         i_envelope_select = (k < 2) ? 2'h1 : 2'h2;
         i_output_polarity = k[0];
         env_step(1'b1);
         chk1(o_envelope_out_pin, ~i_output_polarity);
         env_step(1'b0);
         chk1(o_envelope_out_pin, i_output_polarity);
         chk1(o_carrier_out_pin, i_output_polarity ^ (k >= 2));
      end
      i_envelope_select = 2'h0;
      i_output_polarity = 1'b0;
      env_step(1'b1);
      chk1(o_envelope_out_pin, 1'b0);
      // Receive, every clock counted, reload on
      {i_direction_bit, i_frequency_measure, i_capture_reload, i_timer_interrupt_enable} = 4'h7;
      i_edge_select = 2'h2;
      tick(2);
      chk1(o_receive_active, 1'b1);
      rx_edge(1'b0, 20, 16'h0000, 1'b0, 1'b0);
      rx_edge(1'b1, 30, 16'h0013, 1'b1, 1'b1);
      rx_edge(1'b0, 12, 16'h001d, 1'b0, 1'b1);
      i_edge_select = 2'h1;
      rx_edge(1'b1, 15, 16'h000b, 1'b1, 1'b1);
      rx_edge(1'b0, 12, 16'h000b, 1'b1, 1'b0);
      rx_edge(1'b1, 20, 16'h001a, 1'b1, 1'b1);
      i_edge_select = 2'h0;
      rx_edge(1'b0, 10, 16'h0013, 1'b0, 1'b1);
      rx_edge(1'b1, 10, 16'h0013, 1'b0, 1'b0);
      i_edge_select = 2'h3;
      rx_edge(1'b0, 10, 16'h0013, 1'b0, 1'b1);
      i_capture_reload = 1'b0;
      rx_edge(1'b1, 10, 16'h0009, 1'b1, 1'b1);
      rx_edge(1'b0, 10, 16'h0013, 1'b0, 1'b1);
      i_timer_enable = 1'b0;
      rx_edge(1'b1, 10, 16'h0013, 1'b0, 1'b0);
      i_timer_enable = 1'b1;
      rx_edge(1'b0, 10, 16'h0013, 1'b0, 1'b0);
      rx_edge(1'b1, 10, 16'h0009, 1'b1, 1'b1);
      // Free run until the timer wraps
      for (int n = 0; n < 70000 && o_overflow_flag !== 1'b1; n++) tick(1);
      if (o_overflow_flag !== 1'b1) begin
         miscompares++;
         tally_and_finish();
      end
      tick(5);
      chk16(o_timer_value, 16'h0005);
      chk1(o_overflow_flag, 1'b1);
      chk1(o_irq, 1'b1);
      i_timer_interrupt_enable = 1'b0;
      tick(1);
      chk1(o_irq, 1'b0);
      i_timer_interrupt_enable = 1'b1;
      i_clear_overflow = 1'b1;
      tick(1);
      i_clear_overflow = 1'b0;
      tick(2);
      chk1(o_overflow_flag, 1'b0);
      // Burst counting on carrier ticks of four clocks
      i_frequency_measure = 1'b0;
      i_burst_count_mode = 1'b1;
      tick(2);
      chk16(o_modulator_time, 16'h0001);
      fe.burst(3, 2);
      tick(2);
      chk16(o_modulator_time, 16'h0004);
      chk1(o_timer_interrupt_flag, 1'b0);
      // Any eight clocks hold exactly two carrier ticks of four clocks
      timer_before = o_timer_value;
      tick(8);
      chk16(o_timer_value, timer_before + 16'h0002);
      tick(12);
      chk1(o_timer_interrupt_flag, 1'b1);
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
